// >>> hdl/olo_top.sv
// top: option configuration registers loaded at reset, lockable oscillator control
// assumes: flash option read port and ahb-lite on core_clk_i, cpu held by core_run_o
`timescale 1ns/10ps

// Overview of operation
// - option changes in flash only take effect at the next reset or stop recovery
// - every reset or stop recovery fetches option bits from flash
// - core stays held until option load has completed
// - option configuration registers are invisible to software
// - two-bit oscillator mode field selects oscillator mode, erased gives 11
// - always-on bit 0: brown-out off in stop, else power control bit
// - always-on bit 1: brown-out always enabled, power control cannot disable
// - read-protect 0 blocks code access and limits debugger; 1 allows all
// - program ram mapping 0 is register ram, 1 program ram at E000H
// - write-protect 0 refuses user program and erase, debugger mass erase stays
// - oscillator control relocks after one successful write
// - precision oscillator enable bit switches it, reads 1 after reset
// - crystal enable switches crystal and overrides gpio on both crystal pins
// - watchdog oscillator enable bit switches it, reads 1 after reset
// - primary fail detect bit enables detection and recovery together
// - watchdog fail detect bit enables watchdog oscillator failure detection
// - three-bit clock source field picks system clock, four reserved codes
module olo_top
    import olo_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        stop_recovery_i,
    input  wire logic        stop_mode_i,
    input  wire logic        power_ctl_brownout_i,
    input  wire logic        flash_ack_i,
    input  wire logic [7:0]  flash_rdata_i,
    input  wire logic        hsel_i,
    input  wire logic [15:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             flash_req_o,
    output logic [15:0]      flash_addr_o,
    output logic             core_run_o,
    output logic [1:0]       oscillator_mode_o,
    output logic             brownout_enable_o,
    output logic             code_read_allowed_o,
    output logic             debugger_full_o,
    output logic             pram_as_program_o,
    output logic [15:0]      pram_base_o,
    output logic             user_flash_write_allowed_o,
    output logic             debug_mass_erase_allowed_o,
    output logic             precision_osc_enable_o,
    output logic             crystal_enable_o,
    output logic             crystal_pin_override_o,
    output logic             watchdog_osc_enable_o,
    output logic             primary_osc_fail_detect_o,
    output logic             watchdog_osc_fail_detect_o,
    output logic [2:0]       clock_source_select_o
);

    typedef enum logic [1:0] {
        OLO_LK_LOCKED = 2'b00,
        OLO_LK_KEY1   = 2'b01,
        OLO_LK_OPEN   = 2'b10
    } olo_lock_t;

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    olo_wr_t     wr;
    logic [11:0] rd_idx;
    logic [7:0]  rd_value;
    logic [31:0] hrdata;

    olo_ahb_slave u_bus (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .hsel_i     (hsel_i),
        .haddr_i    (haddr_i),
        .htrans_i   (htrans_i),
        .hwrite_i   (hwrite_i),
        .hready_i   (hready_i),
        .hwdata_i   (hwdata_i),
        .rd_value_i (rd_value),
        .rd_idx_o   (rd_idx),
        .wr_o       (wr),
        .hrdata_o   (hrdata)
    );

    assign hrdata_o = hrdata;

    // ------------------------------------------------------------
    // option fetch
    // ------------------------------------------------------------
    logic       fetch_done;
    logic [7:0] fetch_byte;
    logic       flash_req;

    olo_opt_fetch u_fetch (
        .core_clk_i    (core_clk_i),
        .rst_i         (rst_i),
        .ce_i          (ce_i),
        .start_i       (stop_recovery_i),
        .flash_ack_i   (flash_ack_i),
        .flash_rdata_i (flash_rdata_i),
        .flash_req_o   (flash_req),
        .done_o        (fetch_done),
        .opt_byte_o    (fetch_byte)
    );

    assign flash_req_o = flash_req;

    // hidden option configuration, only a fetch writes it
    olo_opt_t opt;
    logic     loaded;
    logic     core_run;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            opt      <= olo_opt_t'(OPT_ERASED[5:0]);
            loaded   <= 1'b0;
            core_run <= 1'b0;
        end else if (ce_i) begin
            if (stop_recovery_i) begin
                loaded   <= 1'b0;
                core_run <= 1'b0;
            end else if (fetch_done) begin
                opt      <= olo_opt_t'(fetch_byte[5:0]);
                loaded   <= 1'b1;
                core_run <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // oscillator control lock
    // ------------------------------------------------------------
    olo_lock_t   lock_st;
    olo_lock_t   next_lock_st;
    logic [7:0]  osc_ctl;

    wire logic wr_osc    = wr.wr && (wr.idx == OSC_CTL_ZERO_IDX);
    wire logic wr_unlock = wr.wr && (wr.idx == OSC_UNLOCK_IDX);
    wire logic osc_take  = wr_osc && (lock_st == OLO_LK_OPEN);

    always_comb begin
        next_lock_st = lock_st;
        case (lock_st)
            OLO_LK_LOCKED: begin
                if (wr_unlock && wr.data == OSC_UNLOCK_KEY1) begin
                    next_lock_st = OLO_LK_KEY1;
                end
            end
            OLO_LK_KEY1: begin
                if (wr_unlock) begin
                    next_lock_st = (wr.data == OSC_UNLOCK_KEY2) ? OLO_LK_OPEN : OLO_LK_LOCKED;
                end else if (wr_osc) begin
                    next_lock_st = OLO_LK_LOCKED;
                end
            end
            OLO_LK_OPEN: begin
                if (wr_osc) begin
                    next_lock_st = OLO_LK_LOCKED;
                end
            end
            default: begin
                next_lock_st = OLO_LK_LOCKED;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            lock_st <= OLO_LK_LOCKED;
            osc_ctl <= OSC_CTL_ZERO_RST;
        end else if (ce_i) begin
            lock_st <= next_lock_st;
            if (osc_take) begin
                osc_ctl <= wr.data;
            end
        end
    end

    // ------------------------------------------------------------
    // read decode, option registers never appear here
    // ------------------------------------------------------------
    wire logic [7:0] status_val = {6'h00, loaded, lock_st == OLO_LK_OPEN};

    assign rd_value = (rd_idx == OSC_CTL_ZERO_IDX) ? osc_ctl :
                      (rd_idx == OLO_STATUS_IDX)   ? status_val :
                      8'h00;

    // ------------------------------------------------------------
    // option and oscillator effects
    // ------------------------------------------------------------
    wire logic next_bo_en = opt.brownout_always_on_option ? 1'b1 :
                            (stop_mode_i ? 1'b0 : power_ctl_brownout_i);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hreadyout_o                <= 1'b1;
            hresp_o                    <= 1'b0;
            flash_addr_o               <= OPT_FLASH_ADDR;
            core_run_o                 <= 1'b0;
            oscillator_mode_o          <= OLO_MODE_HIGH;
            brownout_enable_o          <= 1'b1;
            code_read_allowed_o        <= 1'b0;
            debugger_full_o            <= 1'b0;
            pram_as_program_o          <= 1'b1;
            pram_base_o                <= PRAM_PROG_BASE;
            user_flash_write_allowed_o <= 1'b0;
            debug_mass_erase_allowed_o <= 1'b1;
            precision_osc_enable_o     <= OSC_CTL_ZERO_RST[PREC_OSC_EN_BIT];
            crystal_enable_o           <= OSC_CTL_ZERO_RST[CRYSTAL_EN_BIT];
            crystal_pin_override_o     <= OSC_CTL_ZERO_RST[CRYSTAL_EN_BIT];
            watchdog_osc_enable_o      <= OSC_CTL_ZERO_RST[WDT_OSC_EN_BIT];
            primary_osc_fail_detect_o  <= OSC_CTL_ZERO_RST[PRIM_FAIL_BIT];
            watchdog_osc_fail_detect_o <= OSC_CTL_ZERO_RST[WDT_FAIL_BIT];
            clock_source_select_o      <= OSC_CTL_ZERO_RST[CLK_SRC_LSB +: 3];
        end else if (ce_i) begin
            core_run_o                 <= core_run && !stop_recovery_i;
            oscillator_mode_o          <= opt.oscillator_mode_option;
            brownout_enable_o          <= next_bo_en;
            // protection is only lifted once the real options are in
            code_read_allowed_o        <= loaded && opt.code_read_protect_option;
            debugger_full_o            <= loaded && opt.code_read_protect_option;
            pram_as_program_o          <= opt.program_ram_mapping_option;
            user_flash_write_allowed_o <= loaded && opt.code_write_protect_option;
            debug_mass_erase_allowed_o <= 1'b1;
            precision_osc_enable_o     <= osc_ctl[PREC_OSC_EN_BIT];
            crystal_enable_o           <= osc_ctl[CRYSTAL_EN_BIT];
            crystal_pin_override_o     <= osc_ctl[CRYSTAL_EN_BIT];
            watchdog_osc_enable_o      <= osc_ctl[WDT_OSC_EN_BIT];
            primary_osc_fail_detect_o  <= osc_ctl[PRIM_FAIL_BIT];
            watchdog_osc_fail_detect_o <= osc_ctl[WDT_FAIL_BIT];
            clock_source_select_o      <= osc_ctl[CLK_SRC_LSB +: 3];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_opt_only_fetch: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $changed(opt) |-> $past(fetch_done && ce_i))
        else $error("option register changed outside a fetch");

    a_recov_refetch: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (stop_recovery_i && ce_i && !flash_req) |=> flash_req)
        else $error("stop recovery did not start an option fetch");

    a_core_after_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
        core_run_o |-> loaded)
        else $error("core released before options loaded");

    a_no_opt_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (hsel_i && htrans_i[1] && hready_i && !hwrite_i && ce_i
            && rd_idx != OSC_CTL_ZERO_IDX && rd_idx != OLO_STATUS_IDX)
            |=> hrdata_o == 32'h0000_0000)
        else $error("unmapped read returned data");

    a_bo_always_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ($past(opt.brownout_always_on_option) && $past(ce_i)) |-> brownout_enable_o)
        else $error("brownout disabled while always on");

    a_bo_stop_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ($past(!opt.brownout_always_on_option && stop_mode_i && ce_i)) |-> !brownout_enable_o)
        else $error("brownout on in stop mode");

    a_write_prot: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ($past(!opt.code_write_protect_option && ce_i)) |-> !user_flash_write_allowed_o)
        else $error("user flash write allowed while protected");

    a_relock_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        osc_take && ce_i |=> lock_st == OLO_LK_LOCKED && osc_ctl == $past(wr.data))
        else $error("oscillator control not stored or not relocked");

    a_locked_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (wr_osc && lock_st != OLO_LK_OPEN) |=> $stable(osc_ctl))
        else $error("locked oscillator control changed");

    a_src_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (osc_take && ce_i) ##1 ce_i |=> clock_source_select_o == $past(wr.data[2:0], 2))
        else $error("clock source output did not follow write");

    a_mode_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i |=> oscillator_mode_o == $past(opt.oscillator_mode_option))
        else $error("oscillator mode output does not follow option");

    a_read_prot: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i |=> {code_read_allowed_o, debugger_full_o}
            == {2{$past(loaded && opt.code_read_protect_option)}})
        else $error("read protection outputs do not follow option");

    a_pram_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i |=> pram_as_program_o == $past(opt.program_ram_mapping_option)
            && pram_base_o == PRAM_PROG_BASE)
        else $error("program ram mapping output does not follow option");

    a_xtal_override: assert property (@(posedge core_clk_i) disable iff (rst_i)
        crystal_pin_override_o == crystal_enable_o)
        else $error("crystal pin override differs from crystal enable");

    a_osc_en_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i |=> {precision_osc_enable_o, watchdog_osc_enable_o}
            == $past({osc_ctl[PREC_OSC_EN_BIT], osc_ctl[WDT_OSC_EN_BIT]}))
        else $error("oscillator enable outputs do not follow register");

    a_fail_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (osc_take && ce_i) ##1 ce_i |=>
            {primary_osc_fail_detect_o, watchdog_osc_fail_detect_o}
            == $past({wr.data[PRIM_FAIL_BIT], wr.data[WDT_FAIL_BIT]}, 2))
        else $error("failure detect outputs did not follow write");

endmodule // olo_top

// >>> hdl/olo_pkg.sv
// package: shared constants and types of the option loader and oscillator control
// assumes: one 100 MHz system clock, word-wide ahb-lite register access
package olo_pkg;

    // ------------------------------------------------------------
    // register map (index form, byte address = 4 x index)
    // ------------------------------------------------------------
    localparam logic [11:0] OSC_CTL_ZERO_IDX  = 12'hF86;
    localparam logic [11:0] OSC_UNLOCK_IDX    = 12'hF87;
    localparam logic [11:0] OLO_STATUS_IDX    = 12'hF88;
    localparam logic [7:0]  OSC_CTL_ZERO_RST  = 8'hA0;
    // unlock keys: arbitrary values
    localparam logic [7:0]  OSC_UNLOCK_KEY1   = 8'h5A;
    localparam logic [7:0]  OSC_UNLOCK_KEY2   = 8'hA5;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PREC_OSC_EN_BIT  = 7;
    localparam int CRYSTAL_EN_BIT   = 6;
    localparam int WDT_OSC_EN_BIT   = 5;
    localparam int PRIM_FAIL_BIT    = 4;
    localparam int WDT_FAIL_BIT     = 3;
    localparam int CLK_SRC_LSB      = 0;
    localparam int OPT_MODE_LSB     = 4;
    localparam int OPT_BO_AO_BIT    = 3;
    localparam int OPT_READ_BIT     = 2;
    localparam int OPT_PRAM_BIT     = 1;
    localparam int OPT_WRITE_BIT    = 0;
    localparam int STAT_UNLOCK_BIT  = 0;
    localparam int STAT_LOADED_BIT  = 1;

    // ------------------------------------------------------------
    // option storage
    // ------------------------------------------------------------
    localparam logic [15:0] OPT_FLASH_ADDR  = 16'h0000;
    localparam logic [15:0] PRAM_PROG_BASE  = 16'hE000;
    localparam logic [7:0]  OPT_ERASED      = 8'hFF;

    typedef enum logic [1:0] {
        OLO_MODE_RC_EXT   = 2'b00,
        OLO_MODE_RSVD     = 2'b01,
        OLO_MODE_MEDIUM   = 2'b10,
        OLO_MODE_HIGH     = 2'b11
    } olo_osc_mode_t;

    typedef enum logic [2:0] {
        OLO_SRC_PRECISION = 3'b000,
        OLO_SRC_CRYSTAL   = 3'b010,
        OLO_SRC_WDT       = 3'b011,
        OLO_SRC_EXT_PIN   = 3'b100
    } olo_clk_src_t;

    typedef struct packed {
        olo_osc_mode_t oscillator_mode_option;
        logic          brownout_always_on_option;
        logic          code_read_protect_option;
        logic          program_ram_mapping_option;
        logic          code_write_protect_option;
    } olo_opt_t;

    typedef struct packed {
        logic        wr;
        logic [11:0] idx;
        logic [7:0]  data;
    } olo_wr_t;

endpackage

// >>> hdl/olo_ahb_slave.sv
// ahb-lite slave front end: turns single word transfers into register strobes
// assumes: one slave on the bus, zero wait states, read value supplied by parent
`timescale 1ns/10ps
module olo_ahb_slave
    import olo_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        hsel_i,
    input  wire logic [15:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic [7:0]  rd_value_i,
    output logic [11:0]      rd_idx_o,
    output olo_wr_t          wr_o,
    output logic [31:0]      hrdata_o
);

    // ------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------
    wire logic take = hsel_i && htrans_i[1] && hready_i;

    logic        wr_pend;
    logic [11:0] wr_idx;

    assign rd_idx_o = haddr_i[13:2];

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_pend  <= 1'b0;
            wr_idx   <= 12'h000;
            hrdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wr_pend <= take && hwrite_i;
            wr_idx  <= haddr_i[13:2];
            // read data flopped at the address phase, stands in the data phase
            if (take && !hwrite_i) begin
                hrdata_o <= {24'h00_0000, rd_value_i};
            end
        end
    end

    // write strobe lives in the data phase, where hwdata is valid
    assign wr_o.wr   = wr_pend && ce_i;
    assign wr_o.idx  = wr_idx;
    assign wr_o.data = hwdata_i[7:0];

endmodule // olo_ahb_slave

// >>> hdl/olo_opt_fetch.sv
// option byte fetch from flash program memory
// assumes: flash read port on the same clock, ack a pulse with valid data
`timescale 1ns/10ps
module olo_opt_fetch
    import olo_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        start_i,
    input  wire logic        flash_ack_i,
    input  wire logic [7:0]  flash_rdata_i,
    output logic             flash_req_o,
    output logic             done_o,
    output logic [7:0]       opt_byte_o
);

    typedef enum logic [1:0] {
        OLO_F_IDLE = 2'b00,
        OLO_F_REQ  = 2'b01,
        OLO_F_DONE = 2'b10
    } olo_fetch_st_t;

    // ------------------------------------------------------------
    // fetch sequence
    // ------------------------------------------------------------
    olo_fetch_st_t st;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st          <= OLO_F_REQ;
            flash_req_o <= 1'b1;
            done_o      <= 1'b0;
            opt_byte_o  <= OPT_ERASED;
        end else if (ce_i) begin
            done_o <= 1'b0;
            case (st)
                OLO_F_IDLE: begin
                    if (start_i) begin
                        st          <= OLO_F_REQ;
                        flash_req_o <= 1'b1;
                    end
                end
                OLO_F_REQ: begin
                    if (flash_ack_i) begin
                        st          <= OLO_F_DONE;
                        flash_req_o <= 1'b0;
                        opt_byte_o  <= flash_rdata_i;
                    end
                end
                OLO_F_DONE: begin
                    // a recovery landing here still gets its own fetch
                    if (start_i) begin
                        st          <= OLO_F_REQ;
                        flash_req_o <= 1'b1;
                    end else begin
                        st     <= OLO_F_IDLE;
                        done_o <= 1'b1;
                    end
                end
                default: begin
                    st <= OLO_F_IDLE;
                end
            endcase
        end
    end

endmodule // olo_opt_fetch

// >>> tb/olo_flash_model.sv
// flash option read port model: answers each option request after a set delay
// assumes: loader holds its request until ack, same clock as the loader
`timescale 1ns/10ps
module olo_flash_model (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       req_i,
    input  wire logic [3:0] wait_i,
    input  wire logic [7:0] opt_i,
    output logic            ack_o,
    output logic [7:0]      rdata_o
);
    logic [3:0] cnt;

    // data valid only with ack; toggled otherwise so a late sample shows
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_o   <= 1'b0;
            cnt     <= 4'h0;
            rdata_o <= 8'h00;
        end else if (ack_o) begin
            ack_o   <= 1'b0;
            cnt     <= 4'h0;
            rdata_o <= ~rdata_o;
        end else if (req_i && cnt == wait_i) begin
            ack_o   <= 1'b1;
            rdata_o <= opt_i;
        end else begin
            cnt     <= req_i ? cnt + 4'h1 : 4'h0;
            rdata_o <= ~rdata_o;
        end
    end
endmodule // olo_flash_model

// >>> tb/olo_tb_top.sv
// testbench: option load at reset and stop recovery, oscillator control over ahb-lite
// assumes: flash model on the option port, single slave so hready is hreadyout
`timescale 1ns/10ps
module olo_tb_top
    import olo_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [15:0] A_OSC = {2'b00, OSC_CTL_ZERO_IDX, 2'b00};
    localparam logic [15:0] A_UNL = {2'b00, OSC_UNLOCK_IDX, 2'b00};
    localparam logic [15:0] A_STA = {2'b00, OLO_STATUS_IDX, 2'b00};
    logic        clk, rst, stop_rec, stop_md, pwr_bo, hsel, hwrite, hready, hresp;
    logic        freq, fack, run, bo, crd, dbg, pram, uwr, dme, pe, ce_x, ovr, we, pf, wf;
    logic [1:0]  htrans, mode;
    logic [2:0]  csel;
    logic [3:0]  fwait;
    logic [7:0]  frd, fopt, v;
    logic [15:0] haddr, pbase, faddr;
    logic [31:0] hwdata, hrdata, rd;
    logic [7:0]  opts [4] = '{8'h00, 8'h1A, 8'h25, 8'hFF};
    int          err_total, n_compared, cyc;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // design and flash
    // ------------------------------------------------------------
    olo_top DUT (.core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .stop_recovery_i(stop_rec),
        .stop_mode_i(stop_md), .power_ctl_brownout_i(pwr_bo), .flash_ack_i(fack),
        .flash_rdata_i(frd), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hsize_i(3'b010), .hwrite_i(hwrite), .hready_i(hready), .hwdata_i(hwdata),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .flash_req_o(freq),
        .flash_addr_o(faddr), .core_run_o(run), .oscillator_mode_o(mode),
        .brownout_enable_o(bo), .code_read_allowed_o(crd), .debugger_full_o(dbg),
        .pram_as_program_o(pram), .pram_base_o(pbase), .user_flash_write_allowed_o(uwr),
        .debug_mass_erase_allowed_o(dme), .precision_osc_enable_o(pe),
        .crystal_enable_o(ce_x), .crystal_pin_override_o(ovr), .watchdog_osc_enable_o(we),
        .primary_osc_fail_detect_o(pf), .watchdog_osc_fail_detect_o(wf),
        .clock_source_select_o(csel));
    olo_flash_model FLASH (.core_clk_i(clk), .rst_i(rst), .req_i(freq), .wait_i(fwait),
        .opt_i(fopt), .ack_o(fack), .rdata_o(frd));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // reset or stop recovery with a given stored option byte, then check loaded outputs
    task automatic load(input logic [7:0] o, input logic [3:0] w, input logic by_stop);
        @(posedge clk);
        fopt  <= o;
        fwait <= w;
        if (by_stop) begin
            stop_rec <= 1'b1;
            @(posedge clk);
            stop_rec <= 1'b0;
        end else begin
            rst <= 1'b1;
            repeat (3) @(posedge clk);
            rst <= 1'b0;
        end
        repeat (3) @(posedge clk);
        #1;
        chk(32'(run), 32'h0);
        while (run !== 1'b1) @(posedge clk);
        #1;
        chk(32'(mode), 32'(o[5:4]));
        chk(32'({crd, dbg}), 32'({2{o[2]}}));
        chk(32'({pram, pbase}), 32'({o[1], PRAM_PROG_BASE}));
        chk(32'({uwr, dme}), 32'({o[0], 1'b1}));
        chk(32'({hresp, hready, faddr}), 32'({1'b0, 1'b1, OPT_FLASH_ADDR}));
    endtask

    task automatic bo_chk(input logic s, input logic p, input logic exp);
        @(posedge clk);
        stop_md <= s;
        pwr_bo  <= p;
        settle();
        chk(32'(bo), 32'(exp));
    endtask

    task automatic complete_run();
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard, run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        stop_rec = 1'b0;
        stop_md = 1'b0;
        pwr_bo = 1'b1;
        hsel = 1'b1;
        haddr = 16'h0000;
        hwrite = 1'b0;
        htrans = 2'b00;
        hwdata = 32'h0000_0000;
        fopt = OPT_ERASED;
        fwait = 4'h0;
        err_total = 0;
        n_compared = 0;
        cyc = 0;
        for (int i = 0; i < 4; i++) begin
            load(opts[i], i[0] ? 4'h7 : 4'h0, 1'b0);
            bo_chk(1'b1, 1'b1, opts[i][3]);
            bo_chk(1'b0, 1'b0, opts[i][3]);
            bo_chk(1'b0, 1'b1, 1'b1);
        end
        @(posedge clk);
        fopt <= 8'h25;
        repeat (10) @(posedge clk);
        #1;
        chk(32'({mode, crd}), 32'h7);
        load(8'h25, 4'h7, 1'b1);
        rdchk(A_OSC, 32'h0000_00A0);
        xfer(A_OSC, 1'b1, 32'h0000_0007);
        rdchk(A_OSC, 32'h0000_00A0);
        settle();
        chk(32'({pe, ce_x, we, pf, wf, csel}), 32'h0000_00A0);
        xfer(16'h0000, 1'b1, 32'h0000_00FF);
        rdchk(16'h0000, 32'h0000_0000);
        rdchk(A_STA, 32'h0000_0002);
        for (int c = 0; c < 8; c++) begin
            // precision oscillator only kept on while it is the source
            v = {c[2:0] == 3'b000, c[1], c[0], c[2], c[0] ^ c[1], c[2:0]};
            xfer(A_UNL, 1'b1, {24'h0, OSC_UNLOCK_KEY1});
            xfer(A_UNL, 1'b1, {24'h0, OSC_UNLOCK_KEY2});
            rdchk(A_STA, 32'h0000_0003);
            xfer(A_OSC, 1'b1, {24'h0, v});
            xfer(A_OSC, 1'b1, {24'h0, ~v});
            rdchk(A_OSC, {24'h0, v});
            settle();
            chk(32'({pe, ce_x, we, pf, wf, csel}), 32'(v));
            chk(32'(ovr), 32'(v[6]));
        end
        rdchk(A_STA, 32'h0000_0002);
        complete_run();
    end
endmodule // olo_tb_top
